// ==== design/stc_tx_map.vh ====
// Address map, field positions, reset values and encodings for the
// transmit configuration bank. Assumes inclusion by bare name.
`ifndef STC_TX_MAP_VH
`define STC_TX_MAP_VH

`define STC_ADDR_W          20
`define STC_ADDR_CAL_HI     20'h3_0925
`define STC_ADDR_CAL_LO     20'h3_0926
`define STC_ADDR_FIFO_CNT   20'h3_0927
`define STC_ADDR_WIDTH_SEL  20'h3_0930
`define STC_ADDR_STARVE_HI  20'h3_0931
`define STC_ADDR_STARVE_LO  20'h3_0932
`define STC_ADDR_HUNGRY_HI  20'h3_0933
`define STC_ADDR_HUNGRY_LO  20'h3_0934
`define STC_ADDR_TRAIN_A    20'h3_0935
`define STC_ADDR_TRAIN_B    20'h3_0936
`define STC_ADDR_TRAIN_C    20'h3_0937
`define STC_ADDR_TRAIN_D    20'h3_0940
`define STC_ADDR_REPEAT_A   20'h3_0941
`define STC_ADDR_REPEAT_B   20'h3_0942
`define STC_ADDR_STATUS     20'h3_0950

`define STC_RESET_BYTE      8'h00
`define STC_HI2_MSB         1
`define STC_HI2_LSB         0

`define STC_CAL_SHADOW_BASE 11'h0400
`define STC_CAL_IDX_W       10

`define STC_STAT_STARVING   2'h0
`define STC_STAT_HUNGRY     2'h1

`define STC_WIDTH_32        2'h0
`define STC_WIDTH_64        2'h1
`define STC_WIDTH_128       2'h2
`define STC_WIDTH_BAD       2'h3

`define STC_FIFO_CNT_RESET   16'h1111
`define STC_WORD_BYTES_RESET 20'h2_1084
`define STC_WIDTH_BAD_RESET  4'h0

`endif

// ==== design/stc_credit_limit.v ====
// Maps a reported port status onto the burst credit it may draw.
// Assumes status reports arrive as one-cycle pulses on ref_clk.
`timescale 1ns/10ps
`include "stc_tx_map.vh"
module stc_credit_limit (
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       statusValid,
  input  wire [1:0] statusCode,
  input  wire [7:0] statusPort,
  input  wire [9:0] starvingLimit,
  input  wire [9:0] hungryLimit,
  output wire       creditValid,
  output wire [7:0] creditPort,
  output wire [9:0] creditBursts
);
  reg       valid_reg;
  reg [7:0] port_reg;
  reg [9:0] bursts_reg;
  reg [9:0] bursts_next;

  always @* begin
    case (statusCode)
      `STC_STAT_STARVING: bursts_next = starvingLimit;
      `STC_STAT_HUNGRY:   bursts_next = hungryLimit;
      default:            bursts_next = 10'h000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      valid_reg  <= 1'b0;
      port_reg   <= 8'h00;
      bursts_reg <= 10'h000;
    end else begin
      valid_reg <= statusValid;
      if (statusValid) begin
        port_reg   <= statusPort;
        bursts_reg <= bursts_next;
      end
    end
  end

  assign creditValid  = valid_reg;
  assign creditPort   = port_reg;
  assign creditBursts = bursts_reg;
endmodule

// ==== design/stc_training_timer.v ====
// Counts transmit data cycles and schedules training insertion.
// Assumes data, burst-end and sequence-done strobes are on ref_clk.
`timescale 1ns/10ps
module stc_training_timer (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        dataCycle,
  input  wire        burstEnd,
  input  wire        seqDone,
  input  wire [31:0] interval,
  input  wire [15:0] repeatCount,
  output wire        trainDue,
  output wire        trainActive,
  output wire [15:0] repeatsLeft
);
  localparam [1:0] ST_COUNT = 2'h0;
  localparam [1:0] ST_DUE   = 2'h1;
  localparam [1:0] ST_SEND  = 2'h2;

  reg [1:0]  state_reg;
  reg [31:0] count_reg;
  reg [15:0] left_reg;
  wire       enabled;
  wire [15:0] firstLoad;

  assign enabled   = (interval != 32'h0000_0000);
  assign firstLoad = (repeatCount == 16'h0000) ? 16'h0001 : repeatCount;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_COUNT;
      count_reg <= 32'h0000_0000;
      left_reg  <= 16'h0000;
    end else begin
      case (state_reg)
        ST_COUNT: begin
          if (!enabled) begin
            count_reg <= 32'h0000_0000;
          end else if (dataCycle) begin
            if (count_reg + 32'h0000_0001 >= interval) begin
              state_reg <= ST_DUE;
            end
            count_reg <= count_reg + 32'h0000_0001;
          end
        end
        ST_DUE: begin
          if (!enabled) begin
            state_reg <= ST_COUNT;
            count_reg <= 32'h0000_0000;
          end else if (burstEnd) begin
            state_reg <= ST_SEND;
            count_reg <= 32'h0000_0000;
            left_reg  <= firstLoad;
          end
        end
        ST_SEND: begin
          if (seqDone) begin
            left_reg <= left_reg - 16'h0001;
            if (left_reg == 16'h0001) begin
              state_reg <= ST_COUNT;
            end
          end
        end
        default: begin
          state_reg <= ST_COUNT;
        end
      endcase
    end
  end

  assign trainDue    = (state_reg == ST_DUE);
  assign trainActive = (state_reg == ST_SEND);
  assign repeatsLeft = left_reg;
endmodule

// ==== design/stc_tx_config.v ====
// Transmit configuration bank with shadow calendar walker,
// credit limit lookup and training scheduler.
// Assumes a same-clock register port and same-clock data-path strobes.
// Bank decodes are registered alongside the field registers.
//
// Overview of operation
// - Shadow calendar length is ten bits from two registers.
// - Bank 0 FIFO code 00,01,10,11 gives 1,2,4,8 virtual FIFOs.
// - One register holds four 2-bit FIFO codes, bank 0 first.
// - Width code 00/01/10 is 32/64/128 bits; 11 is invalid.
// - Starving ports get at most the programmed 10-bit burst count.
// - Hungry ports get at most a separate 10-bit burst count.
// - Burst limits: top two bits in one register, low eight next.
// - A programmable 32-bit limit bounds the gap between trainings.
// - Training interval bytes a,b,c,d run most to least significant.
// - A zero training interval disables periodic training.
// - Each due training repeats a count built from two bytes.
// - Shadow calendar sits at calendar locations 1024 to 2046.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "stc_tx_map.vh"
module stc_tx_config (
  ref_clk,
  sys_rst,
  regAddr,
  regWrData,
  regWrStrobe,
  regRdStrobe,
  regRdData,
  regRdValid,
  calAdvance,
  calRestart,
  shadowCalLength,
  shadowCalAddr,
  bankFifoCount,
  bankWidthCode,
  bankWordBytes,
  widthInvalid,
  statusValid,
  statusCode,
  statusPort,
  creditValid,
  creditPort,
  creditBursts,
  dataCycle,
  burstEnd,
  seqDone,
  trainingInterval,
  trainDue,
  trainActive
);
  input  wire                     ref_clk;
  input  wire                     sys_rst;
  input  wire [`STC_ADDR_W-1:0]   regAddr;
  input  wire [7:0]               regWrData;
  input  wire                     regWrStrobe;
  input  wire                     regRdStrobe;
  output wire [7:0]               regRdData;
  output wire                     regRdValid;
  input  wire                     calAdvance;
  input  wire                     calRestart;
  output wire [9:0]               shadowCalLength;
  output wire [10:0]              shadowCalAddr;
  output wire [15:0]              bankFifoCount;
  output wire [7:0]               bankWidthCode;
  output wire [19:0]              bankWordBytes;
  output wire [3:0]               widthInvalid;
  input  wire                     statusValid;
  input  wire [1:0]               statusCode;
  input  wire [7:0]               statusPort;
  output wire                     creditValid;
  output wire [7:0]               creditPort;
  output wire [9:0]               creditBursts;
  input  wire                     dataCycle;
  input  wire                     burstEnd;
  input  wire                     seqDone;
  output wire [31:0]              trainingInterval;
  output wire                     trainDue;
  output wire                     trainActive;

  // Field of bank n; bank 0 occupies the most significant bits of the register
  function [1:0] bankField;
    input [7:0] regVal;
    input [1:0] bank;
    begin
      case (bank)
        2'h0:    bankField = regVal[7:6];
        2'h1:    bankField = regVal[5:4];
        2'h2:    bankField = regVal[3:2];
        default: bankField = regVal[1:0];
      endcase
    end
  endfunction

  // Virtual FIFO count from its code
  function [3:0] fifoCount;
    input [1:0] code;
    begin
      case (code)
        2'h0:    fifoCount = 4'h1;
        2'h1:    fifoCount = 4'h2;
        2'h2:    fifoCount = 4'h4;
        default: fifoCount = 4'h8;
      endcase
    end
  endfunction

  // Bytes per data word from width code, zero when invalid
  function [4:0] wordBytes;
    input [1:0] code;
    begin
      case (code)
        `STC_WIDTH_32:  wordBytes = 5'h04;
        `STC_WIDTH_64:  wordBytes = 5'h08;
        `STC_WIDTH_128: wordBytes = 5'h10;
        default:        wordBytes = 5'h00;
      endcase
    end
  endfunction

  // Ten-bit value from a two-bit upper and eight-bit lower register
  function [9:0] join10;
    input [7:0] upper;
    input [7:0] lower;
    begin
      join10 = {upper[`STC_HI2_MSB:`STC_HI2_LSB], lower};
    end
  endfunction

  reg [7:0]  calHi_reg;
  reg [7:0]  calLo_reg;
  reg [7:0]  fifoCnt_reg;
  reg [7:0]  widthSel_reg;
  reg [7:0]  starveHi_reg;
  reg [7:0]  starveLo_reg;
  reg [7:0]  hungryHi_reg;
  reg [7:0]  hungryLo_reg;
  reg [7:0]  trainA_reg;
  reg [7:0]  trainB_reg;
  reg [7:0]  trainC_reg;
  reg [7:0]  trainD_reg;
  reg [7:0]  repeatA_reg;
  reg [7:0]  repeatB_reg;
  reg [7:0]  rdData_reg;
  reg [7:0]  rdData_next;
  reg        rdValid_reg;
  reg [9:0]  calIdx_reg;
  reg [10:0] calAddr_reg;
  reg [9:0]  calIdx_next;
  reg [15:0] fifoCount_reg;
  reg [19:0] wordBytes_reg;
  reg [3:0]  widthBad_reg;

  wire [9:0]  calLength;
  wire [9:0]  starvingLimit;
  wire [9:0]  hungryLimit;
  wire [31:0] interval;
  wire [15:0] repeatCount;
  wire [15:0] repeatsLeft;
  wire [7:0]  statusByte;
  wire [15:0] fifoCount_next;
  wire [19:0] wordBytes_next;
  wire [3:0]  widthBad_next;

  // Register writes
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      calHi_reg    <= `STC_RESET_BYTE;
      calLo_reg    <= `STC_RESET_BYTE;
      fifoCnt_reg  <= `STC_RESET_BYTE;
      widthSel_reg <= `STC_RESET_BYTE;
      starveHi_reg <= `STC_RESET_BYTE;
      starveLo_reg <= `STC_RESET_BYTE;
      hungryHi_reg <= `STC_RESET_BYTE;
      hungryLo_reg <= `STC_RESET_BYTE;
      trainA_reg   <= `STC_RESET_BYTE;
      trainB_reg   <= `STC_RESET_BYTE;
      trainC_reg   <= `STC_RESET_BYTE;
      trainD_reg   <= `STC_RESET_BYTE;
      repeatA_reg  <= `STC_RESET_BYTE;
      repeatB_reg  <= `STC_RESET_BYTE;
    end else if (regWrStrobe) begin
      case (regAddr)
        `STC_ADDR_CAL_HI:    calHi_reg    <= regWrData;
        `STC_ADDR_CAL_LO:    calLo_reg    <= regWrData;
        `STC_ADDR_FIFO_CNT:  fifoCnt_reg  <= regWrData;
        `STC_ADDR_WIDTH_SEL: widthSel_reg <= regWrData;
        `STC_ADDR_STARVE_HI: starveHi_reg <= regWrData;
        `STC_ADDR_STARVE_LO: starveLo_reg <= regWrData;
        `STC_ADDR_HUNGRY_HI: hungryHi_reg <= regWrData;
        `STC_ADDR_HUNGRY_LO: hungryLo_reg <= regWrData;
        `STC_ADDR_TRAIN_A:   trainA_reg   <= regWrData;
        `STC_ADDR_TRAIN_B:   trainB_reg   <= regWrData;
        `STC_ADDR_TRAIN_C:   trainC_reg   <= regWrData;
        `STC_ADDR_TRAIN_D:   trainD_reg   <= regWrData;
        `STC_ADDR_REPEAT_A:  repeatA_reg  <= regWrData;
        `STC_ADDR_REPEAT_B:  repeatB_reg  <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // Read mux
  always @* begin
    case (regAddr)
      `STC_ADDR_CAL_HI:    rdData_next = calHi_reg;
      `STC_ADDR_CAL_LO:    rdData_next = calLo_reg;
      `STC_ADDR_FIFO_CNT:  rdData_next = fifoCnt_reg;
      `STC_ADDR_WIDTH_SEL: rdData_next = widthSel_reg;
      `STC_ADDR_STARVE_HI: rdData_next = starveHi_reg;
      `STC_ADDR_STARVE_LO: rdData_next = starveLo_reg;
      `STC_ADDR_HUNGRY_HI: rdData_next = hungryHi_reg;
      `STC_ADDR_HUNGRY_LO: rdData_next = hungryLo_reg;
      `STC_ADDR_TRAIN_A:   rdData_next = trainA_reg;
      `STC_ADDR_TRAIN_B:   rdData_next = trainB_reg;
      `STC_ADDR_TRAIN_C:   rdData_next = trainC_reg;
      `STC_ADDR_TRAIN_D:   rdData_next = trainD_reg;
      `STC_ADDR_REPEAT_A:  rdData_next = repeatA_reg;
      `STC_ADDR_REPEAT_B:  rdData_next = repeatB_reg;
      `STC_ADDR_STATUS:    rdData_next = statusByte;
      default:             rdData_next = 8'h00;
    endcase
  end

  // Read data stands for one cycle only
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regRdStrobe;
      rdData_reg  <= regRdStrobe ? rdData_next : 8'h00;
    end
  end

  assign regRdData  = rdData_reg;
  assign regRdValid = rdValid_reg;

  // Assembled configuration values
  assign calLength     = join10(calHi_reg, calLo_reg);
  assign starvingLimit = join10(starveHi_reg, starveLo_reg);
  assign hungryLimit   = join10(hungryHi_reg, hungryLo_reg);
  assign interval = {trainA_reg, trainB_reg,
                     trainC_reg, trainD_reg};
  assign repeatCount = {repeatA_reg, repeatB_reg};

  assign shadowCalLength  = calLength;
  assign trainingInterval = interval;

  // Per-bank decode of the write data, kept in flip-flops below; width codes come unregistered from widthSel_reg
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : gBank
      localparam [1:0] BANK = b;
      wire [1:0] newCode;
      assign newCode = bankField(regWrData, BANK);
      assign bankWidthCode[2*b+1:2*b] = bankField(widthSel_reg, BANK);
      assign fifoCount_next[4*b+3:4*b] = fifoCount(newCode);
      assign wordBytes_next[5*b+4:5*b] = wordBytes(newCode);
      assign widthBad_next[b] = (newCode == `STC_WIDTH_BAD);
    end
  endgenerate

  // Decoded bank settings change with their field registers
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      fifoCount_reg <= `STC_FIFO_CNT_RESET;
      wordBytes_reg <= `STC_WORD_BYTES_RESET;
      widthBad_reg  <= `STC_WIDTH_BAD_RESET;
    end else if (regWrStrobe) begin
      if (regAddr == `STC_ADDR_FIFO_CNT) begin
        fifoCount_reg <= fifoCount_next;
      end
      if (regAddr == `STC_ADDR_WIDTH_SEL) begin
        wordBytes_reg <= wordBytes_next;
        widthBad_reg  <= widthBad_next;
      end
    end
  end

  assign bankFifoCount = fifoCount_reg;
  assign bankWordBytes = wordBytes_reg;
  assign widthInvalid  = widthBad_reg;

  // Shadow calendar walker
  always @* begin
    if (calRestart || calLength == 10'h000) begin
      calIdx_next = 10'h000;
    end else if (calAdvance) begin
      if (calIdx_reg + 10'h001 >= calLength) begin
        calIdx_next = 10'h000;
      end else begin
        calIdx_next = calIdx_reg + 10'h001;
      end
    end else begin
      calIdx_next = calIdx_reg;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      calIdx_reg  <= 10'h000;
      calAddr_reg <= `STC_CAL_SHADOW_BASE;
    end else begin
      calIdx_reg  <= calIdx_next;
      calAddr_reg <= `STC_CAL_SHADOW_BASE + {1'b0, calIdx_next};
    end
  end

  assign shadowCalAddr = calAddr_reg;

  // Block state for software
  assign statusByte = {4'h0, trainActive, trainDue,
                       |widthInvalid, (repeatsLeft != 16'h0000)};

  // Credit lookup and training scheduler
  stc_credit_limit uCredit (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .statusValid   (statusValid),
    .statusCode    (statusCode),
    .statusPort    (statusPort),
    .starvingLimit (starvingLimit),
    .hungryLimit   (hungryLimit),
    .creditValid   (creditValid),
    .creditPort    (creditPort),
    .creditBursts  (creditBursts)
  );

  stc_training_timer uTrain (
    .ref_clk     (ref_clk),
    .sys_rst     (sys_rst),
    .dataCycle   (dataCycle),
    .burstEnd    (burstEnd),
    .seqDone     (seqDone),
    .interval    (interval),
    .repeatCount (repeatCount),
    .trainDue    (trainDue),
    .trainActive (trainActive),
    .repeatsLeft (repeatsLeft)
  );
endmodule

// ==== test/stc_tx_config_chk.sv ====
// Port-level checker for the transmit configuration bank.
// Assumes one clock ref_clk and synchronous reset sys_rst.
`timescale 1ns/10ps
`include "stc_tx_map.vh"
module stc_tx_config_chk (
  input logic        ref_clk,
  input logic        sys_rst,
  input logic [19:0] regAddr,
  input logic [7:0]  regWrData,
  input logic        regWrStrobe,
  input logic        regRdStrobe,
  input logic [7:0]  regRdData,
  input logic        regRdValid,
  input logic        calAdvance,
  input logic        calRestart,
  input logic [9:0]  shadowCalLength,
  input logic [10:0] shadowCalAddr,
  input logic [7:0]  bankWidthCode,
  input logic [19:0] bankWordBytes,
  input logic [3:0]  widthInvalid,
  input logic        statusValid,
  input logic [7:0]  statusPort,
  input logic        creditValid,
  input logic [9:0]  creditBursts,
  input logic [7:0]  creditPort,
  input logic        burstEnd,
  input logic [31:0] trainingInterval,
  input logic        trainDue,
  input logic        trainActive
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_rd_idle: assert property (
    !$past(regRdStrobe) |-> !regRdValid && regRdData == 8'h00)
    else $error("Read data outside its slot");
  a_rd_train_d: assert property (
    regRdStrobe && regAddr == `STC_ADDR_TRAIN_D
    |=> regRdValid && regRdData == trainingInterval[7:0])
    else $error("Interval low byte mismatch");
  a_cal_len_hi: assert property (
    regWrStrobe && regAddr == `STC_ADDR_CAL_HI
    |=> {6'h00, shadowCalLength[9:8]} == ($past(regWrData) & 8'h03))
    else $error("Calendar length top bits wrong");
  a_cal_restart: assert property (
    calRestart ##1 !calAdvance |=> shadowCalAddr == 11'h400)
    else $error("Restart did not return to shadow base");
  a_word_bytes: assert property (
    widthInvalid[0] == (bankWidthCode[1:0] == 2'h3) &&
    bankWordBytes[4:0] == (widthInvalid[0] ? 5'h00 :
                           5'h04 << bankWidthCode[1:0]))
    else $error("Bank 0 word size wrong");
  a_credit_pulse: assert property (
    statusValid |=> creditValid && creditPort == $past(statusPort))
    else $error("Credit answer missing");
  a_credit_hold: assert property (
    !statusValid |=> !creditValid && $stable(creditBursts))
    else $error("Credit changed without status");
  a_train_off: assert property (
    trainingInterval == 32'h0000_0000 &&
    $past(trainingInterval) == 32'h0000_0000 |-> !trainDue)
    else $error("Training due with zero interval");
  a_due_active: assert property (
    trainDue && burstEnd |=> trainActive && !trainDue)
    else $error("Training not started at burst end");
endmodule
bind stc_tx_config stc_tx_config_chk i_stc_tx_config_chk (
  .ref_clk, .sys_rst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe,
  .regRdData, .regRdValid, .calAdvance, .calRestart, .shadowCalLength,
  .shadowCalAddr, .bankWidthCode, .bankWordBytes, .widthInvalid,
  .statusValid, .statusPort, .creditValid, .creditBursts, .creditPort,
  .burstEnd, .trainingInterval, .trainDue, .trainActive
);

// ==== test/stc_link_partner.sv ====
// Far-side model that finishes training sequences while asked.
// Assumes trainActive is a level on ref_clk; slowMode stretches gaps.
`timescale 1ns/10ps
module stc_link_partner (
  input  logic ref_clk,
  input  logic sys_rst,
  input  logic trainActive,
  input  logic slowMode,
  output logic seqDone
);
  logic [2:0] waitCnt_reg;
  logic       done_reg;
  assign seqDone = done_reg;
  always @(posedge ref_clk) begin
    if (sys_rst || !trainActive) begin
      waitCnt_reg <= 3'h0;
      done_reg    <= 1'b0;
    end else if (waitCnt_reg == (slowMode ? 3'h4 : 3'h1)) begin
      waitCnt_reg <= 3'h0;
      done_reg    <= 1'b1;
    end else begin
      waitCnt_reg <= waitCnt_reg + 3'h1;
      done_reg    <= 1'b0;
    end
  end
endmodule

// ==== test/stc_tx_config_test.sv ====
// Self-checking bench for the transmit configuration bank.
// Assumes design files and stc_tx_map.vh on the include path.
`timescale 1ns/10ps
`include "stc_tx_map.vh"
module stc_tx_config_test;
  logic        ref_clk, sys_rst, regWrStrobe, regRdStrobe, regRdValid;
  logic        calAdvance, calRestart, statusValid, creditValid;
  logic        dataCycle, burstEnd, seqDone, trainDue, trainActive;
  logic        slowMode;
  logic [19:0] regAddr, bankWordBytes;
  logic [19:0] addrTab [12];
  logic [7:0]  regWrData, regRdData, bankWidthCode, statusPort, creditPort;
  logic [9:0]  shadowCalLength, creditBursts;
  logic [10:0] shadowCalAddr;
  logic [15:0] bankFifoCount;
  logic [3:0]  widthInvalid;
  logic [1:0]  statusCode;
  logic [31:0] trainingInterval;
  int          fails = 0;
  int          samples_checked = 0;

  stc_tx_config i_stc_tx_config (.ref_clk, .sys_rst, .regAddr, .regWrData,
    .regWrStrobe, .regRdStrobe, .regRdData, .regRdValid, .calAdvance,
    .calRestart, .shadowCalLength, .shadowCalAddr, .bankFifoCount,
    .bankWidthCode, .bankWordBytes, .widthInvalid, .statusValid,
    .statusCode, .statusPort, .creditValid, .creditPort, .creditBursts,
    .dataCycle, .burstEnd, .seqDone, .trainingInterval, .trainDue,
    .trainActive);
  stc_link_partner i_stc_link_partner (.ref_clk, .sys_rst, .trainActive,
    .slowMode, .seqDone);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [19:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1;
    chk(regRdValid, 1'b1);
    chk(regRdData, exp);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 12; i++) rdc(addrTab[i], 8'h00);
    chk(bankFifoCount, 16'h1111);
    chk(bankWordBytes, 20'h2_1084);
    chk(shadowCalAddr, 11'h400);
  endtask

  task automatic t_readback;
    for (int i = 0; i < 12; i++) wr(addrTab[i], {4'hA, i[3:0]});
    for (int i = 0; i < 12; i++) rdc(addrTab[i], {4'hA, i[3:0]});
    chk(trainingInterval, 32'hA8A9_AAAB);
    wr(20'h3_0938, 8'h5A);
    rdc(20'h3_0938, 8'h00);
  endtask

  task automatic t_calendar;
    wr(`STC_ADDR_CAL_HI, 8'hFE);
    wr(`STC_ADDR_CAL_LO, 8'h05);
    chk(shadowCalLength, 10'h205);
    @(posedge ref_clk);
    calRestart <= 1'b1;
    @(posedge ref_clk);
    calRestart <= 1'b0;
    @(posedge ref_clk);
    calAdvance <= 1'b1;
    @(posedge ref_clk);
    calAdvance <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(shadowCalAddr, 11'h401);
    wr(`STC_ADDR_CAL_HI, 8'h00);
    wr(`STC_ADDR_CAL_LO, 8'h02);
    @(posedge ref_clk);
    calAdvance <= 1'b1;
    @(posedge ref_clk);
    calAdvance <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(shadowCalAddr, 11'h400);
  endtask

  task automatic t_banks;
    wr(`STC_ADDR_FIFO_CNT, 8'h1B);
    chk(bankFifoCount, 16'h8421);
    wr(`STC_ADDR_FIFO_CNT, 8'hE4);
    chk(bankFifoCount, 16'h1248);
    wr(`STC_ADDR_WIDTH_SEL, 8'h1B);
    chk(bankWidthCode, 8'hE4);
    chk(bankWordBytes, 20'h0_4104);
    chk(widthInvalid, 4'h8);
  endtask

  task automatic t_credit;
    wr(`STC_ADDR_STARVE_HI, 8'hFF);
    wr(`STC_ADDR_STARVE_LO, 8'hA5);
    wr(`STC_ADDR_HUNGRY_HI, 8'h02);
    wr(`STC_ADDR_HUNGRY_LO, 8'h5A);
    @(posedge ref_clk);
    statusValid <= 1'b1;
    statusCode <= `STC_STAT_STARVING;
    statusPort <= 8'h03;
    @(posedge ref_clk);
    statusCode <= `STC_STAT_HUNGRY;
    statusPort <= 8'h07;
    #1;
    chk(creditBursts, 10'h3A5);
    @(posedge ref_clk);
    statusCode <= 2'h2;
    #1;
    chk(creditBursts, 10'h25A);
    @(posedge ref_clk);
    statusValid <= 1'b0;
    #1;
    chk(creditBursts, 10'h000);
  endtask

  task automatic t_training;
    int n = 0;
    for (int i = 8; i < 11; i++) wr(addrTab[i], 8'h00);
    wr(`STC_ADDR_TRAIN_D, 8'h03);
    wr(`STC_ADDR_REPEAT_A, 8'h00);
    wr(`STC_ADDR_REPEAT_B, 8'h02);
    rdc(`STC_ADDR_REPEAT_B, 8'h02);
    @(posedge ref_clk);
    slowMode <= 1'b1;
    dataCycle <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(trainDue, 1'b0);
    @(posedge ref_clk);
    dataCycle <= 1'b0;
    #1;
    chk(trainDue, 1'b1);
    rdc(`STC_ADDR_STATUS, 8'h06);
    @(posedge ref_clk);
    burstEnd <= 1'b1;
    @(posedge ref_clk);
    burstEnd <= 1'b0;
    #1;
    chk(trainActive, 1'b1);
    for (int i = 0; i < 40 && trainActive === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      if (seqDone === 1'b1) n++;
    end
    chk(n, 2);
    chk(trainActive, 1'b0);
  endtask

  task automatic t_zero;
    wr(`STC_ADDR_TRAIN_D, 8'h00);
    @(posedge ref_clk);
    dataCycle <= 1'b1;
    repeat (5) @(posedge ref_clk);
    dataCycle <= 1'b0;
    #1;
    chk(trainDue, 1'b0);
    rdc(`STC_ADDR_STATUS, 8'h02);
  endtask

  initial begin
    #100000;
    fails++;
    print_verdict;
  end

  initial begin
    {sys_rst, regWrStrobe, regRdStrobe, calAdvance, calRestart} = 5'h1F;
    {regWrStrobe, regRdStrobe, calAdvance, calRestart} = 4'h0;
    {statusValid, dataCycle, burstEnd, slowMode} = 4'h0;
    {regAddr, regWrData, statusCode, statusPort} = 38'h0;
    addrTab = '{`STC_ADDR_CAL_HI, `STC_ADDR_CAL_LO, `STC_ADDR_FIFO_CNT,
      `STC_ADDR_WIDTH_SEL, `STC_ADDR_STARVE_HI, `STC_ADDR_STARVE_LO,
      `STC_ADDR_HUNGRY_HI, `STC_ADDR_HUNGRY_LO, `STC_ADDR_TRAIN_A,
      `STC_ADDR_TRAIN_B, `STC_ADDR_TRAIN_C, `STC_ADDR_TRAIN_D};
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_readback;
    t_calendar;
    t_banks;
    t_credit;
    t_training;
    t_zero;
    print_verdict;
  end
endmodule
